// *** hdl/mrc_pkg.sv ***
package mrc_pkg;
  // Register port offsets
  localparam logic [3:0] MRC_OFS_LVSEL  = 4'h0;
  localparam logic [3:0] MRC_OFS_FLAGS  = 4'h1;
  localparam logic [3:0] MRC_OFS_STATUS = 4'h2;
  localparam logic [3:0] MRC_OFS_IRQST  = 4'h3;
  localparam logic [3:0] MRC_OFS_IRQMSK = 4'h4;
  localparam logic [3:0] MRC_OFS_PDREQ  = 4'h5;

  // Flag register field positions
  localparam int MRC_BIT_BROWNOUT = 2;
  localparam int MRC_BIT_BADSEL   = 1;
  localparam int MRC_BIT_WDBAD    = 0;
  localparam int MRC_BIT_KEEP     = 7;

  // Reset values, plus the other valid select codes
  localparam logic [7:0] MRC_LVSEL_POR    = 8'h55;
  localparam logic [7:0] MRC_LVSEL_V1     = 8'h33;
  localparam logic [7:0] MRC_LVSEL_V2     = 8'h99;
  localparam logic [7:0] MRC_LVSEL_V3     = 8'hAA;
  localparam logic [7:0] MRC_PORT_INIT    = 8'hFF;
  localparam logic [7:0] MRC_SYSMODE_INIT = 8'h03;
  localparam logic [7:0] MRC_WDCTRL_INIT  = 8'h53;
  localparam logic [7:0] MRC_ZERO8        = 8'h00;

  // Timing
  localparam int CLK_MHZ            = 40;
  localparam int STARTUP_DELAY_US   = 1;
  localparam int STARTUP_CYC        = STARTUP_DELAY_US * CLK_MHZ;
  localparam int QUALIFY_TIME_US    = 1;
  localparam int QUALIFY_CYC        = QUALIFY_TIME_US * CLK_MHZ;
  localparam int SLOW_RC_WAIT       = 2;

  // Reset cause of the most recent reset
  typedef enum logic [2:0] {
    MRC_RS_POWERON, MRC_RS_PIN, MRC_RS_BROWNOUT, MRC_RS_BADSEL, MRC_RS_WD_RUN, MRC_RS_WD_PD
  } mrc_cause_t;

  typedef enum logic [1:0] {MRC_ST_HOLD, MRC_ST_START, MRC_ST_RUN} mrc_state_t;
endpackage

// *** hdl/mrc_sync.sv ***
`timescale 1ns/1ps
module mrc_sync import mrc_pkg::*; #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Data
  input  wire logic [W-1:0] async_in,
  input  wire logic [W-1:0] rst_val,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // Both stages hold the input xor its idle level, so a cleared stage reads as rst_val
  // First stage feeds only the second stage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in ^ rst_val;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q ^ rst_val;
endmodule // mrc_sync

// *** hdl/mrc_reset_ctrl.sv ***
// The address map and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
// What this block does
// - Power-on clears the program counter
// - Power-on sets port data, direction all ones
// - Start-up delay after reset pin release
// - Reset pin low clears PC, restarts
// - Brownout resets only after qualifying time
// - Four valid select codes, all 2.1V
// - Bad select code resets, restores select
// - Bad select reset sets its flag
// - Brownout reset keeps select register
// - Select register powers up at 0x55
// - Brownout reset disabled in power down
// - Flags bits 2,1; bits 6-3 zero; sw clears
// - Running watchdog reset like pin, sets timeout
// - Power-down watchdog clears only PC, SP
// - Timeout and powerdown flags per reset type
// - Power-on: irq off, watchdog, timers, SP
// - Fixed initial values for mode registers, the same for every reset type
module mrc_reset_ctrl import mrc_pkg::*; #(
  parameter int STARTUP_CYCLES = STARTUP_CYC,
  parameter int QUALIFY_CYCLES = QUALIFY_CYC,
  parameter int SLOW_WAIT      = SLOW_RC_WAIT
) (
  // Clock and power-on reset
  input  wire logic       CLOCK,
  input  wire logic       RST,
  // Reset sources
  input  wire logic       EXT_RESET_N,
  input  wire logic       BROWNOUT_LOW,
  input  wire logic       WATCHDOG_TIMEOUT,
  input  wire logic       POWERDOWN_ENTER,
  input  wire logic       SLOW_RC_CLOCK,
  // Register port
  input  wire logic [3:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  input  wire logic       REG_WR,
  input  wire logic       REG_RD,
  output logic      [7:0] REG_RDATA,
  // Reset outputs to the core
  output logic            CORE_RESET,
  output logic            CPU_RUN,
  output logic            PC_CLEAR,
  output logic            SP_TOP,
  output logic            UNIT_INIT,
  output logic            POWERDOWN_ACTIVE,
  output logic            TIMEOUT_FLAG,
  output logic            POWERDOWN_FLAG,
  output logic      [7:0] PORT_INIT_VALUE,
  output logic      [7:0] SYSMODE_INIT_VALUE,
  output logic      [7:0] WDCTRL_INIT_VALUE,
  output logic            IRQ
);
  // Counter widths hold the full count, end point included
  localparam int SCW = $clog2(STARTUP_CYCLES + 1);
  localparam int QCW = $clog2(QUALIFY_CYCLES + 1);

  function automatic logic code_valid(input logic [7:0] c);
    code_valid = (c == MRC_LVSEL_POR) || (c == MRC_LVSEL_V1) ||
                 (c == MRC_LVSEL_V2)  || (c == MRC_LVSEL_V3);
  endfunction

  // Write strobe decode for one register offset
  function automatic logic wr_hit(input logic wr, input logic [3:0] addr, input logic [3:0] ofs);
    wr_hit = wr && (addr == ofs);
  endfunction

  // True on the slow-clock edge that ends the two-to-three cycle wait
  function automatic logic slow_wait_done(input logic edge_seen, input logic [1:0] cnt, input logic [1:0] lim);
    slow_wait_done = edge_seen && (cnt == lim);
  endfunction

  // Synchronise pins: reset pin, brownout, watchdog, power-down request, slow clock
  logic [4:0] sync_w;
  mrc_sync #(.W(5)) u_sync (
    .clk      (CLOCK),
    .rst      (RST),
    .async_in ({EXT_RESET_N, BROWNOUT_LOW, WATCHDOG_TIMEOUT, POWERDOWN_ENTER, SLOW_RC_CLOCK}),
    .rst_val  (5'b1_0000),
    .sync_out (sync_w)
  );
  logic pin_n_s, bo_s, wd_s, pd_s, src_s;
  assign {pin_n_s, bo_s, wd_s, pd_s, src_s} = sync_w;

  // Sequencer, cause and register state
  mrc_state_t state_q;
  mrc_cause_t cause_q;
  logic [7:0]     lvsel_q;
  logic           bo_flag_q, bad_flag_q, wdbad_flag_q, keep_q;
  logic           to_q, pdf_q, pd_q;
  logic [SCW-1:0] start_cnt_q;
  logic [QCW-1:0] qual_cnt_q;
  logic [1:0]     rc_cnt_q;
  logic           src_prev_q, wd_prev_q;
  logic           bo_pend_q, bad_pend_q;
  logic [2:0]     irq_st_q, irq_msk_q;
  logic           rst_req;
  logic           bo_qualified, bad_code, rc_edge, wd_rise;
  logic           bo_fire, bad_fire, wd_run_fire, wd_pd_fire, pin_fire;
  // Core held in reset: outside run, or a reset request this cycle
  logic           hold_core;

  assign rc_edge  = src_s & ~src_prev_q;
  assign wd_rise  = wd_s & ~wd_prev_q;
  assign bad_code = ~code_valid(lvsel_q);
  assign bo_qualified = (qual_cnt_q == QCW'(QUALIFY_CYCLES));

  // Reset fires once the slow-clock wait has elapsed
  assign bo_fire     = bo_pend_q & slow_wait_done(rc_edge, rc_cnt_q, 2'(SLOW_WAIT));
  assign bad_fire    = bad_pend_q & slow_wait_done(rc_edge, rc_cnt_q, 2'(SLOW_WAIT));
  assign pin_fire    = ~pin_n_s & (state_q == MRC_ST_RUN);
  assign wd_run_fire = wd_rise & ~pd_q & (state_q == MRC_ST_RUN);
  assign wd_pd_fire  = wd_rise & pd_q;
  assign rst_req     = pin_fire | bo_fire | bad_fire | wd_run_fire;
  assign hold_core   = (state_q != MRC_ST_RUN) | rst_req;

  // Brownout qualification, held off in power down
  // Counter saturates, so a long dip stays qualified and requests again after each restart
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      qual_cnt_q <= '0;
    end else if (!bo_s || pd_q) begin
      qual_cnt_q <= '0;
    end else if (!bo_qualified) begin
      qual_cnt_q <= qual_cnt_q + QCW'(1);
    end
  end

  // Slow-clock wait before brownout or bad-code reset
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      src_prev_q <= 1'b0;
      wd_prev_q  <= 1'b0;
      bo_pend_q  <= 1'b0;
      bad_pend_q <= 1'b0;
      rc_cnt_q   <= '0;
    end else begin
      src_prev_q <= src_s;
      wd_prev_q  <= wd_s;
      // Pending requests die once any reset takes the core out of run
      if (bo_fire || bad_fire || state_q != MRC_ST_RUN) begin
        bo_pend_q  <= 1'b0;
        bad_pend_q <= 1'b0;
        rc_cnt_q   <= '0;
      end else begin
        if (bo_qualified && !pd_q && !bo_pend_q) begin
          bo_pend_q <= 1'b1;
        end
        if (bad_code && !bad_pend_q) begin
          bad_pend_q <= 1'b1;
        end
        // Counting from detection gives two to three slow cycles
        if ((bo_pend_q || bad_pend_q) && rc_edge && rc_cnt_q != 2'(SLOW_WAIT)) begin
          rc_cnt_q <= rc_cnt_q + 2'd1;
        end
      end
    end
  end

  // Sequencer: hold while the reset pin is low, then start-up delay
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      state_q     <= MRC_ST_HOLD;
      start_cnt_q <= '0;
    end else begin
      case (state_q)
        MRC_ST_HOLD: begin
          start_cnt_q <= '0;
          // Only the pin holds the core; other sources fire once and let go
          if (pin_n_s) begin
            state_q <= MRC_ST_START;
          end
        end
        MRC_ST_START: begin
          if (!pin_n_s) begin
            state_q <= MRC_ST_HOLD;
          end else if (start_cnt_q == SCW'(STARTUP_CYCLES)) begin
            state_q <= MRC_ST_RUN;
          end else begin
            start_cnt_q <= start_cnt_q + SCW'(1);
          end
        end
        MRC_ST_RUN: begin
          if (rst_req) begin
            state_q <= MRC_ST_HOLD;
          end
        end
        default: state_q <= MRC_ST_HOLD;
      endcase
    end
  end

  // Cause, power-down and status flags
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      cause_q <= MRC_RS_POWERON;
      pd_q    <= 1'b0;
      to_q    <= 1'b0;
      pdf_q   <= 1'b0;
    end else begin
      if (wd_pd_fire) begin
        cause_q <= MRC_RS_WD_PD;
        pd_q    <= 1'b0;
        to_q    <= 1'b1;
        pdf_q   <= 1'b1;
      end else if (wd_run_fire) begin
        cause_q <= MRC_RS_WD_RUN;
        to_q    <= 1'b1;
      end else if (bad_fire) begin
        cause_q <= MRC_RS_BADSEL;
      end else if (bo_fire) begin
        cause_q <= MRC_RS_BROWNOUT;
      end else if (pin_fire) begin
        cause_q <= MRC_RS_PIN;
      end else if (pd_s && state_q == MRC_ST_RUN) begin
        pd_q  <= 1'b1;
        pdf_q <= 1'b1;
      end
      // Leaving power down drops the state but keeps the sticky flag
      if (!pd_s && !wd_pd_fire) begin
        pd_q <= 1'b0;
      end
    end
  end

  // Select register: bad-code reset restores it, brownout keeps it
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      lvsel_q <= MRC_LVSEL_POR;
    end else if (bad_fire) begin
      lvsel_q <= MRC_LVSEL_POR;
    end else if (wr_hit(REG_WR, REG_ADDR, MRC_OFS_LVSEL)) begin
      lvsel_q <= REG_WDATA;
    end
  end

  // Reset flags: hardware sets, software writes zero; set wins
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      bo_flag_q    <= 1'b0;
      bad_flag_q   <= 1'b0;
      wdbad_flag_q <= 1'b0;
      keep_q       <= 1'b0;
    end else begin
      if (wr_hit(REG_WR, REG_ADDR, MRC_OFS_FLAGS)) begin
        keep_q <= REG_WDATA[MRC_BIT_KEEP];
        if (!REG_WDATA[MRC_BIT_BROWNOUT]) begin
          bo_flag_q <= 1'b0;
        end
        if (!REG_WDATA[MRC_BIT_BADSEL]) begin
          bad_flag_q <= 1'b0;
        end
        // Watchdog-control flag has no source in this block; it only clears
        if (!REG_WDATA[MRC_BIT_WDBAD]) begin
          wdbad_flag_q <= 1'b0;
        end
      end
      if (bo_fire) begin
        bo_flag_q <= 1'b1;
      end
      if (bad_fire) begin
        bad_flag_q <= 1'b1;
      end
    end
  end

  // Interrupt status: pin, brownout, bad-code, watchdog resets
  logic [2:0] irq_ev;
  assign irq_ev = {wd_run_fire | wd_pd_fire, bo_fire | bad_fire, pin_fire};

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      irq_st_q  <= '0;
      irq_msk_q <= '0;
    end else begin
      if (wr_hit(REG_WR, REG_ADDR, MRC_OFS_IRQMSK)) begin
        irq_msk_q <= REG_WDATA[2:0];
      end
      // Write one to clear; an event in the same cycle still sets
      if (wr_hit(REG_WR, REG_ADDR, MRC_OFS_IRQST)) begin
        irq_st_q <= (irq_st_q & ~REG_WDATA[2:0]) | irq_ev;
      end else begin
        irq_st_q <= irq_st_q | irq_ev;
      end
    end
  end

  // Read port, data one cycle after the strobe
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      REG_RDATA <= MRC_ZERO8;
    end else if (REG_RD) begin
      case (REG_ADDR)
        MRC_OFS_LVSEL:  REG_RDATA <= lvsel_q;
        MRC_OFS_FLAGS:  REG_RDATA <= {keep_q, 4'h0, bo_flag_q, bad_flag_q, wdbad_flag_q};
        MRC_OFS_STATUS: REG_RDATA <= {2'b00, pd_q, cause_q, to_q, pdf_q};
        MRC_OFS_IRQST:  REG_RDATA <= {5'h00, irq_st_q};
        MRC_OFS_IRQMSK: REG_RDATA <= {5'h00, irq_msk_q};
        // Unmapped offsets read as zero so software sees no stale data
        default:        REG_RDATA <= MRC_ZERO8;
      endcase
    end else begin
      REG_RDATA <= MRC_ZERO8;
    end
  end

  // Core reset outputs, asserted at once by RST, released on a clock edge
  // A power-down watchdog wake raises no core reset, so unit init follows
  // the core hold alone and the other units keep their state

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      CORE_RESET         <= 1'b1;
      CPU_RUN            <= 1'b0;
      PC_CLEAR           <= 1'b1;
      SP_TOP             <= 1'b1;
      UNIT_INIT          <= 1'b1;
      PORT_INIT_VALUE    <= MRC_PORT_INIT;
      SYSMODE_INIT_VALUE <= MRC_SYSMODE_INIT;
      WDCTRL_INIT_VALUE  <= MRC_WDCTRL_INIT;
      POWERDOWN_ACTIVE   <= 1'b0;
      TIMEOUT_FLAG       <= 1'b0;
      POWERDOWN_FLAG     <= 1'b0;
      IRQ                <= 1'b0;
    end else begin
      CORE_RESET         <= hold_core;
      CPU_RUN            <= ~hold_core & ~pd_q;
      PC_CLEAR           <= hold_core | wd_pd_fire;
      SP_TOP             <= hold_core | wd_pd_fire;
      UNIT_INIT          <= hold_core;
      PORT_INIT_VALUE    <= MRC_PORT_INIT;
      SYSMODE_INIT_VALUE <= MRC_SYSMODE_INIT;
      WDCTRL_INIT_VALUE  <= MRC_WDCTRL_INIT;
      POWERDOWN_ACTIVE   <= pd_q;
      TIMEOUT_FLAG       <= to_q;
      POWERDOWN_FLAG     <= pdf_q;
      IRQ                <= |(irq_st_q & irq_msk_q);
    end
  end
endmodule // mrc_reset_ctrl

// *** verification/mrc_reset_ctrl_asserts.sv ***
`timescale 1ns/1ps
module mrc_reset_ctrl_asserts (
  // Clock and reset
  input wire logic       CLOCK,
  input wire logic       RST,
  // Pin and register port
  input wire logic       EXT_RESET_N,
  input wire logic       REG_RD,
  input wire logic [7:0] REG_RDATA,
  // Core side
  input wire logic       CORE_RESET,
  input wire logic       CPU_RUN,
  input wire logic       PC_CLEAR,
  input wire logic       SP_TOP,
  input wire logic       UNIT_INIT,
  input wire logic       POWERDOWN_ACTIVE,
  input wire logic       TIMEOUT_FLAG,
  input wire logic       POWERDOWN_FLAG,
  input wire logic [7:0] PORT_INIT_VALUE,
  input wire logic [7:0] SYSMODE_INIT_VALUE,
  input wire logic [7:0] WDCTRL_INIT_VALUE
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  sequence s_pin_held; !EXT_RESET_N [*4]; endsequence
  sequence s_pin_freed; s_pin_held ##1 EXT_RESET_N; endsequence

  property p_pin_resets; s_pin_held |=> CORE_RESET; endproperty
  a_pin_resets: assert property (p_pin_resets) else $error("pin low did not reset core");
  // Two sync stages plus start-up keep reset at least six cycles past the pin edge
  property p_startup_hold; s_pin_freed |-> CORE_RESET [*6]; endproperty
  a_startup_hold: assert property (p_startup_hold) else $error("start-up delay too short");
  property p_release_pin; $fell(CORE_RESET) |-> EXT_RESET_N && $past(EXT_RESET_N, 3); endproperty
  a_release_pin: assert property (p_release_pin) else $error("released while pin low");
  property p_clears; CORE_RESET |-> PC_CLEAR && SP_TOP && UNIT_INIT; endproperty
  a_clears: assert property (p_clears) else $error("reset without pc, sp, unit init");
  property p_init_in_reset; UNIT_INIT |-> CORE_RESET; endproperty
  a_init_in_reset: assert property (p_init_in_reset) else $error("unit init outside reset");
  property p_init_values;
    PORT_INIT_VALUE == 8'hFF && SYSMODE_INIT_VALUE == 8'h03 && WDCTRL_INIT_VALUE == 8'h53;
  endproperty
  a_init_values: assert property (p_init_values) else $error("wrong initial values");
  property p_run_gate; CPU_RUN |-> !CORE_RESET && !POWERDOWN_ACTIVE; endproperty
  a_run_gate: assert property (p_run_gate) else $error("running in reset or power down");
  property p_flags_sticky; !$fell(TIMEOUT_FLAG) && !$fell(POWERDOWN_FLAG); endproperty
  a_flags_sticky: assert property (p_flags_sticky) else $error("status flag cleared");
  property p_flag_pair; POWERDOWN_FLAG |-> TIMEOUT_FLAG; endproperty
  a_flag_pair: assert property (p_flag_pair) else $error("power-down flag without timeout");
  property p_rdata_idle; !$past(REG_RD) |-> REG_RDATA == 8'h00; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
endmodule // mrc_reset_ctrl_asserts

bind mrc_reset_ctrl mrc_reset_ctrl_asserts u_chk (
  .CLOCK(CLOCK), .RST(RST), .EXT_RESET_N(EXT_RESET_N), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
  .CORE_RESET(CORE_RESET), .CPU_RUN(CPU_RUN), .PC_CLEAR(PC_CLEAR), .SP_TOP(SP_TOP),
  .UNIT_INIT(UNIT_INIT), .POWERDOWN_ACTIVE(POWERDOWN_ACTIVE), .TIMEOUT_FLAG(TIMEOUT_FLAG),
  .POWERDOWN_FLAG(POWERDOWN_FLAG), .PORT_INIT_VALUE(PORT_INIT_VALUE),
  .SYSMODE_INIT_VALUE(SYSMODE_INIT_VALUE), .WDCTRL_INIT_VALUE(WDCTRL_INIT_VALUE)
);

// *** verification/mrc_pin_network.sv ***
`timescale 1ns/1ps
module mrc_pin_network #(
  parameter int CHARGE_CYCLES = 3
) (
  // Clock
  input  wire logic clk,
  // Switch closed while high
  input  wire logic press,
  // Reset pin, active low
  output logic      ext_reset_n
);
  int unsigned charge_q = 0;

  // The capacitor starts empty, so the pin also lags the supply at power-on
  always @(posedge clk) begin
    if (press) begin
      charge_q <= 0;
    end else if (charge_q < CHARGE_CYCLES) begin
      charge_q <= charge_q + 1;
    end
  end
  assign ext_reset_n = (charge_q >= CHARGE_CYCLES);
endmodule // mrc_pin_network

// *** verification/mcu_reset_controller_tb.sv ***
`timescale 1ns/1ps
module mcu_reset_controller_tb import mrc_pkg::*;;
  localparam int SU = 4;
  logic       clock, rst, brown, wdog, pdown, press, wr, rd, ext_n, rd_seen;
  logic       core_rst, pd_act, to_fl, pd_fl, irq, pc_clr, irq_a;
  logic [2:0] sc;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, code;
  logic [7:0] valid [4];
  logic [7:0] exp_q [$];
  logic [7:0] msk_q [$];
  int         mismatches, checked, seed, n;

  mrc_reset_ctrl #(.STARTUP_CYCLES(SU), .QUALIFY_CYCLES(4), .SLOW_WAIT(2)) uut (
    .CLOCK(clock), .RST(rst), .EXT_RESET_N(ext_n), .BROWNOUT_LOW(brown), .WATCHDOG_TIMEOUT(wdog),
    .POWERDOWN_ENTER(pdown), .SLOW_RC_CLOCK(sc[2]), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr),
    .REG_RD(rd), .REG_RDATA(rdata), .CORE_RESET(core_rst), .CPU_RUN(), .PC_CLEAR(pc_clr), .SP_TOP(),
    .UNIT_INIT(), .POWERDOWN_ACTIVE(pd_act), .TIMEOUT_FLAG(to_fl), .POWERDOWN_FLAG(pd_fl),
    .PORT_INIT_VALUE(), .SYSMODE_INIT_VALUE(), .WDCTRL_INIT_VALUE(), .IRQ(irq)
  );
  mrc_pin_network #(.CHARGE_CYCLES(3)) u_pin (.clk(clock), .press(press), .ext_reset_n(ext_n));

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // Slow RC clock at one eighth of the system rate
  always @(posedge clock) sc <= sc + 3'd1;

  task automatic summarize();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic cmp(logic [7:0] got, logic [7:0] exp, string what);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Read data is due only in the cycle after the strobe
  always @(posedge clock) begin
    if (rd_seen) begin
      if (exp_q.size() == 0) cmp(8'h01, 8'h00, "unexpected read");
      else cmp(rdata & msk_q.pop_front(), exp_q.pop_front(), "read data");
    end
    rd_seen <= rd;
  end

  task automatic bus(logic w, logic [3:0] a, logic [7:0] d, logic [7:0] m);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    if (!w) begin
      exp_q.push_back(d & m);
      msk_q.push_back(m);
    end
    @(posedge clock);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  task automatic wait_for(ref logic s, input logic v, input int lim);
    n = 0;
    while (s !== v && n < lim) begin
      @(posedge clock);
      n++;
    end
    if (s !== v) begin
      cmp(8'h01, 8'h00, "wait timed out");
      summarize();
    end
  endtask

  task automatic wd_pulse();
    wdog <= 1'b1;
    repeat (3) @(posedge clock);
    wdog <= 1'b0;
  endtask

  initial begin
    {brown, wdog, pdown, press, wr, rd, rd_seen, sc, addr, wdata} = '0;
    valid = '{MRC_LVSEL_POR, MRC_LVSEL_V1, MRC_LVSEL_V2, MRC_LVSEL_V3};
    seed = 81;
    rst = 1'b1;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    wait_for(core_rst, 1'b0, 200);
    bus(0, MRC_OFS_LVSEL, MRC_LVSEL_POR, 8'hFF);
    bus(0, MRC_OFS_FLAGS, 8'h00, 8'h7A);
    bus(0, 4'hC, 8'h00, 8'hFF);
    foreach (valid[i]) begin
      bus(1, MRC_OFS_LVSEL, valid[i], 8'h00);
      bus(0, MRC_OFS_LVSEL, valid[i], 8'hFF);
    end
    repeat (40) @(posedge clock);
    cmp(8'(core_rst), 8'h00, "valid code reset");
    $display("test power-on and select codes done");
    press <= 1'b1;
    repeat (6) @(posedge clock);
    cmp(8'(pc_clr), 8'h01, "pc clear on pin");
    press <= 1'b0;
    wait_for(core_rst, 1'b0, 100);
    cmp(8'(n >= 3 + 2 + SU + 1), 8'h01, "start-up delay");
    cmp(8'(to_fl), 8'h00, "timeout after pin");
    $display("test pin reset done");
    code = 8'($random(seed));
    if (code inside {valid}) code ^= 8'h01;
    bus(1, MRC_OFS_LVSEL, code, 8'h00);
    wait_for(core_rst, 1'b1, 100);
    wait_for(core_rst, 1'b0, 100);
    bus(0, MRC_OFS_LVSEL, MRC_LVSEL_POR, 8'hFF);
    bus(0, MRC_OFS_FLAGS, 8'h02, 8'h02);
    bus(0, MRC_OFS_STATUS, {3'h0, MRC_RS_BADSEL, 2'h0}, 8'h3F);
    bus(0, MRC_OFS_IRQST, 8'h02, 8'h02);
    bus(1, MRC_OFS_IRQMSK, 8'h00, 8'h00);
    repeat (2) @(negedge clock);
    irq_a = irq;
    cmp(8'(irq_a), 8'h00, "irq while masked");
    bus(1, MRC_OFS_IRQMSK, 8'hFF, 8'h00);
    repeat (2) @(negedge clock);
    cmp(8'(irq), 8'h01, "irq when unmasked");
    bus(1, MRC_OFS_IRQMSK, irq_a ? 8'h00 : 8'hFF, 8'h00);
    bus(1, MRC_OFS_IRQST, 8'hFF, 8'h00);
    repeat (2) @(negedge clock);
    cmp(8'(irq), 8'h00, "irq after clear");
    bus(1, MRC_OFS_FLAGS, 8'h00, 8'h00);
    bus(0, MRC_OFS_FLAGS, 8'h00, 8'h06);
    $display("test bad select code done");
    bus(1, MRC_OFS_LVSEL, MRC_LVSEL_V1, 8'h00);
    brown <= 1'b1;
    repeat (2) @(posedge clock);
    brown <= 1'b0;
    repeat (40) @(posedge clock);
    cmp(8'(core_rst), 8'h00, "short dip");
    brown <= 1'b1;
    wait_for(core_rst, 1'b1, 200);
    brown <= 1'b0;
    wait_for(core_rst, 1'b0, 200);
    bus(0, MRC_OFS_LVSEL, MRC_LVSEL_V1, 8'hFF);
    bus(0, MRC_OFS_FLAGS, 8'h04, 8'h06);
    $display("test brownout done");
    wd_pulse();
    wait_for(core_rst, 1'b1, 50);
    wait_for(core_rst, 1'b0, 100);
    cmp({6'h00, to_fl, pd_fl}, 8'h02, "run watchdog flags");
    pdown <= 1'b1;
    brown <= 1'b1;
    repeat (60) @(posedge clock);
    brown <= 1'b0;
    cmp(8'(core_rst), 8'h00, "brownout in power down");
    cmp(8'(pd_act), 8'h01, "power down active");
    wd_pulse();
    wait_for(pc_clr, 1'b1, 50);
    cmp(8'(core_rst), 8'h00, "power-down watchdog reset");
    cmp({6'h00, to_fl, pd_fl}, 8'h03, "power-down watchdog flags");
    $display("test watchdog done");
    pdown <= 1'b0;
    rst <= 1'b1;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    cmp({6'h00, to_fl, pd_fl}, 8'h00, "power-on flags");
    bus(0, MRC_OFS_LVSEL, MRC_LVSEL_POR, 8'hFF);
    repeat (2) @(posedge clock);
    $display("test second power-on done");
    summarize();
  end
endmodule // mcu_reset_controller_tb
